//--- rtl/exec_pkg.sv
// Shared constants and types for the instruction execution core.
package exec_pkg;
   // Control registers at the top of the register file.
   localparam logic [7:0] IMR_ADDR = 8'hFB;
   localparam logic [7:0] FLAGS_ADDR = 8'hFC;
   localparam logic [7:0] RP_ADDR = 8'hFD;
   localparam logic [7:0] SPH_ADDR = 8'hFE;
   localparam logic [7:0] SPL_ADDR = 8'hFF;
   localparam int RF_DEPTH = 256;
   // Flag bit positions inside the flag byte.
   localparam int FC = 7;
   localparam int FZ = 6;
   localparam int FS = 5;
   localparam int FV = 4;
   localparam int FD = 3;
   localparam int FH = 2;
   // Global interrupt enable inside the mask register.
   localparam logic [7:0] GIE_MASK = 8'h80;
   // Register address prefix that names a working register.
   localparam logic [3:0] WR_BANK = 4'hE;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [15:0] WORD_ONE = 16'h0001;
   localparam logic [15:0] WORD_TWO = 16'h0002;
   localparam logic [15:0] WORD_THREE = 16'h0003;
   localparam logic [15:0] WORD_MAX_POS = 16'h7FFF;
   localparam logic [15:0] WORD_MIN_NEG = 16'h8000;
   // Full opcodes.
   localparam logic [7:0] OP_CALL_DA = 8'hD6, OP_CALL_IRR = 8'hD4;
   localparam logic [7:0] OP_SUB_EXIT = 8'hAF, OP_INT_EXIT = 8'hBF;
   localparam logic [7:0] OP_RCF = 8'hCF, OP_SCF = 8'hDF, OP_CCF = 8'hEF;
   localparam logic [7:0] OP_MASK_ALL = 8'h8F, OP_UNMASK_ALL = 8'h9F;
   localparam logic [7:0] OP_JP_IRR = 8'h30, OP_GROUP_SEL = 8'h31;
   localparam logic [7:0] OP_ZERO_R = 8'hB0, OP_ZERO_IR = 8'hB1;
   localparam logic [7:0] OP_INV_R = 8'h60, OP_INV_IR = 8'h61;
   localparam logic [7:0] OP_INC_R = 8'h20, OP_INC_IR = 8'h21;
   localparam logic [7:0] OP_DNW_R = 8'h80, OP_DNW_IR = 8'h81;
   localparam logic [7:0] OP_UPW_R = 8'hA0, OP_UPW_IR = 8'hA1;
   localparam logic [7:0] OP_POP_R = 8'h50, OP_POP_IR = 8'h51;
   localparam logic [7:0] OP_PUSH_R = 8'h70, OP_PUSH_IR = 8'h71;
   localparam logic [7:0] OP_LD_RX = 8'hC7, OP_LD_XR = 8'hD7;
   localparam logic [7:0] OP_LD_RIR = 8'hE3, OP_LD_IRR = 8'hF3;
   localparam logic [7:0] OP_LD_GG = 8'hE4, OP_LD_GIG = 8'hE5;
   localparam logic [7:0] OP_LD_GIM = 8'hE6, OP_LD_IGIM = 8'hE7;
   localparam logic [7:0] OP_LD_IGG = 8'hF5;
   // Low nibbles of the compact and two-operand rows.
   localparam logic [3:0] LO_COUNT_DOWN_BRANCH = 4'hA, LO_JR = 4'hB, LO_LDIM = 4'hC;
   localparam logic [3:0] LO_JP = 4'hD, LO_INC = 4'hE;
   localparam logic [3:0] LO_LDRG = 4'h8, LO_LDGR = 4'h9;
   localparam logic [3:0] LO_RR = 4'h2, LO_RIR = 4'h3, LO_GG = 4'h4;
   localparam logic [3:0] LO_GIG = 4'h5, LO_GIM = 4'h6, LO_IGIM = 4'h7;
   localparam logic [2:0] MEM_LO3 = 3'h1;
   localparam logic [3:0] HI_TCM = 4'h6, HI_CP = 4'hA;
   // Operations of the byte unit; the first seven equal the row nibble.
   typedef enum logic [3:0] {
      A_ADD = 4'h0, A_ADC = 4'h1, A_SUB = 4'h2, A_SBC = 4'h3,
      A_OR = 4'h4, A_AND = 4'h5, A_TCM = 4'h6, A_INC = 4'h8,
      A_COM = 4'h9, A_CP = 4'hA, A_NONE = 4'hF
   } alu_op_t;
   // Gray coded sequencer states.
   typedef enum logic {ST_IDLE = 1'b0, ST_MEM = 1'b1} state_t;
endpackage

//--- rtl/alu8.sv
// Eight-bit arithmetic and logic unit with flag generation.
module alu8 (
   input exec_pkg::alu_op_t op,
   input logic [7:0] a,
   input logic [7:0] b,
   input logic [7:0] flags_in,
   output logic [7:0] res,
   output logic [7:0] flags_out,
   output logic wr
);
   import exec_pkg::*;

   logic [8:0] wide; // Sum or difference with carry out.
   logic [4:0] half; // Low nibble result with half carry.
   logic cin; // Carry or borrow in.
   logic sub; // Subtracting forms.

   // Adder shared by every arithmetic form, so one carry chain serves all.
   always_comb begin
      cin = (op == A_ADC || op == A_SBC) ? flags_in[FC] : 1'b0;
      sub = (op == A_SUB || op == A_SBC || op == A_CP);
      if (sub) begin
         wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      end else begin
         wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      end
   end

   // Result, write enable and flags for each operation.
   always_comb begin
      res = wide[7:0];
      wr = 1'b1;
      flags_out = flags_in;
      unique case (op)
         A_ADD, A_ADC, A_SUB, A_SBC: begin
            flags_out[FC] = wide[8];
            flags_out[FD] = sub;
            flags_out[FH] = half[4];
         end
         A_CP: begin
            wr = 1'b0;
            flags_out[FC] = wide[8];
         end
         A_OR: res = a | b;
         A_AND: res = a & b;
         A_TCM: begin
            res = ~a & b;
            wr = 1'b0;
         end
         A_COM: res = ~a;
         A_INC: res = wide[7:0];
         default: wr = 1'b0;
      endcase
      if (op != A_NONE) begin
         flags_out[FZ] = (res == BYTE_ZERO);
         flags_out[FS] = res[7];
         flags_out[FV] = 1'b0;
         if (op == A_CP || op == A_SUB || op == A_SBC) begin
            flags_out[FV] = (a[7] ^ b[7]) & (res[7] ^ a[7]);
         end else if (op == A_ADD || op == A_ADC || op == A_INC) begin
            flags_out[FV] = ~(a[7] ^ b[7]) & (res[7] ^ a[7]);
         end
      end
   end
endmodule // alu8

//--- rtl/mcu_instruction_execution.sv
// Instruction execution core of an 8-bit microcomputer with its register file.
module mcu_instruction_execution #(
   parameter logic [15:0] PC_RESET = 16'h0000,
   parameter int NWP = 4
) (
   input logic CLK_SYS,
   input logic RST_N,
   input logic INSTR_VALID,
   input logic [7:0] INSTR_OPC,
   input logic [7:0] INSTR_B1,
   input logic [7:0] INSTR_B2,
   input logic [1:0] INSTR_LEN,
   output logic INSTR_READY,
   output logic MEM_REQ,
   output logic MEM_EXT,
   output logic MEM_WE,
   output logic [15:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   input logic [7:0] MEM_RDATA,
   input logic MEM_ACK,
   input logic [7:0] REG_ADDR,
   input logic [7:0] REG_WDATA,
   input logic REG_WR,
   input logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic [15:0] PC_VALUE
);
   import exec_pkg::*;

   logic [7:0] rf_q [RF_DEPTH]; // Register file, control bytes included.
   logic [7:0] wa [NWP]; // Write port addresses.
   logic [7:0] wd [NWP]; // Write port data.
   logic [NWP-1:0] we; // Write port enables.
   int unsigned nw; // Next free write port.
   state_t state_q, state_d; // Sequencer state.
   logic [15:0] pc_q, pc_d; // Program counter.
   logic ready_q; // Ready for the next instruction.
   logic mem_req_q, mem_ext_q, mem_we_q, mem_auto_q;
   logic [15:0] mem_addr_q;
   logic [7:0] mem_wdata_q, mem_tgt_q, mem_r_q, mem_pair_q, rdata_q;
   logic mem_go; // Start a memory transfer.
   logic [7:0] m_tgt, m_wdata;
   logic [15:0] m_addr;
   logic [7:0] o, b1, b2, rp, fl, interrupt_mask_reg, oa, adst, aa, ab, ares, aflags;
   logic [3:0] hi, lo;
   logic [15:0] sp, pcn, pv, nv;
   logic take, two_op, awr;
   alu_op_t aop;

   // Working register address inside the current group.
   function automatic logic [7:0] wreg(input logic [7:0] p, input logic [3:0] r);
      return {p[7:4], r};
   endfunction

   // Full register address; the working prefix maps into the group.
   function automatic logic [7:0] radr(input logic [7:0] p, input logic [7:0] a);
      return (a[7:4] == WR_BANK) ? {p[7:4], a[3:0]} : a;
   endfunction

   // Condition test on the flag byte.
   function automatic logic cond(input logic [3:0] cc, input logic [7:0] f);
      logic t;
      unique case (cc[2:0])
         3'h0: t = 1'b0;
         3'h1: t = f[FS] ^ f[FV];
         3'h2: t = f[FZ] | (f[FS] ^ f[FV]);
         3'h3: t = f[FC] | f[FZ];
         3'h4: t = f[FV];
         3'h5: t = f[FS];
         3'h6: t = f[FZ];
         3'h7: t = f[FC];
      endcase
      return cc[3] ? ~t : t;
   endfunction

   // Signed displacement widened to the counter width.
   function automatic logic [15:0] sext(input logic [7:0] d);
      return {{8{d[7]}}, d};
   endfunction

   // Reads a byte pair, high byte first.
   function automatic logic [15:0] pair(input logic [7:0] a);
      return {rf_q[a], rf_q[a + BYTE_ONE]};
   endfunction

   // Claims the next write port for one register file byte.
   task automatic put(input logic [7:0] adr, input logic [7:0] dat);
      wa[nw] = adr;
      wd[nw] = dat;
      we[nw] = 1'b1;
      nw = nw + 1;
   endtask

   assign o = INSTR_OPC;
   assign b1 = INSTR_B1;
   assign b2 = INSTR_B2;
   assign hi = o[7:4];
   assign lo = o[3:0];
   assign rp = rf_q[RP_ADDR];
   assign fl = rf_q[FLAGS_ADDR];
   assign interrupt_mask_reg = rf_q[IMR_ADDR];
   // Stack pointer read byte by byte; a function call with a constant argument would not follow writes.
   assign sp = {rf_q[SPH_ADDR], rf_q[SPL_ADDR]};
   assign take = INSTR_VALID && ready_q;
   // Counter value past the current instruction.
   assign pcn = pc_q + {14'h0000, INSTR_LEN};
   // Single operand address: even opcode direct, odd indirect.
   assign oa = o[0] ? rf_q[radr(rp, b1)] : radr(rp, b1);
   assign two_op = (lo >= LO_RR) && (lo <= LO_IGIM) && (hi <= HI_TCM || hi == HI_CP);

   // Operand selection for the byte unit.
   always_comb begin
      aop = A_NONE;
      adst = BYTE_ZERO;
      ab = BYTE_ZERO;
      if (two_op) begin
         aop = alu_op_t'(hi);
         case (lo)
            LO_RR: begin
               adst = wreg(rp, b1[7:4]);
               ab = rf_q[wreg(rp, b1[3:0])];
            end
            LO_RIR: begin
               adst = wreg(rp, b1[7:4]);
               ab = rf_q[rf_q[wreg(rp, b1[3:0])]];
            end
            LO_GG: begin
               adst = radr(rp, b2);
               ab = rf_q[radr(rp, b1)];
            end
            LO_GIG: begin
               adst = radr(rp, b2);
               ab = rf_q[rf_q[radr(rp, b1)]];
            end
            LO_GIM: begin
               adst = radr(rp, b1);
               ab = b2;
            end
            LO_IGIM: begin
               adst = rf_q[radr(rp, b1)];
               ab = b2;
            end
            default: ;
         endcase
      end else if (o == OP_INC_R || o == OP_INC_IR) begin
         aop = A_INC;
         adst = oa;
         ab = BYTE_ONE;
      end else if (lo == LO_INC) begin
         aop = A_INC;
         adst = wreg(rp, hi);
         ab = BYTE_ONE;
      end else if (o == OP_INV_R || o == OP_INV_IR) begin
         aop = A_COM;
         adst = oa;
      end
   end

   assign aa = rf_q[adst];

   // Byte unit; compare and mask test only report flags.
   alu8 u_alu (
      .op(aop),
      .a(aa),
      .b(ab),
      .flags_in(fl),
      .res(ares),
      .flags_out(aflags),
      .wr(awr)
   );

   // Execution: register file writes, counter and memory start.
   always_comb begin
      nw = 0;
      for (int i = 0; i < NWP; i++) begin
         wa[i] = BYTE_ZERO;
         wd[i] = BYTE_ZERO;
      end
      we = '0;
      pc_d = pc_q;
      state_d = state_q;
      mem_go = 1'b0;
      m_tgt = wreg(rp, b1[7:4]);
      m_wdata = rf_q[wreg(rp, b1[7:4])];
      m_addr = pair(wreg(rp, b1[3:0]));
      pv = pair(o[0] ? rf_q[radr(rp, b1)] : radr(rp, b1));
      nv = pv;
      if (state_q == ST_MEM) begin
         // Transfer ends on the acknowledge; read data and steps land.
         if (MEM_ACK) begin
            state_d = ST_IDLE;
            if (!mem_we_q) begin
               put(mem_tgt_q, MEM_RDATA);
            end
            if (mem_auto_q) begin
               nv = pair(mem_pair_q) + WORD_ONE;
               put(mem_r_q, rf_q[mem_r_q] + BYTE_ONE);
               put(mem_pair_q, nv[15:8]);
               put(mem_pair_q + BYTE_ONE, nv[7:0]);
            end
         end
      end else if (take) begin
         pc_d = pcn;
         if (aop != A_NONE) begin
            // Result first so that the flag write wins on byte 252.
            if (awr) begin
               put(adst, ares);
            end
            put(FLAGS_ADDR, aflags);
         end else if ((o[3:1] == MEM_LO3) && o[7] && !o[5]) begin
            // Memory moves: bit 6 picks program memory, bit 4 a write.
            mem_go = 1'b1;
            state_d = ST_MEM;
            if (o[0]) begin
               m_tgt = rf_q[wreg(rp, b1[7:4])];
               m_wdata = rf_q[rf_q[wreg(rp, b1[7:4])]];
            end
         end else begin
            unique case (o)
               OP_ZERO_R, OP_ZERO_IR: put(oa, BYTE_ZERO);
               OP_DNW_R, OP_DNW_IR, OP_UPW_R, OP_UPW_IR: begin
                  nv = o[5] ? pv + WORD_ONE : pv - WORD_ONE;
                  put(o[0] ? oa : {oa[7:1], 1'b0}, nv[15:8]);
                  put((o[0] ? oa : {oa[7:1], 1'b0}) + BYTE_ONE, nv[7:0]);
                  put(FLAGS_ADDR, {fl[FC], nv == 16'h0000, nv[15],
                     nv == (o[5] ? WORD_MIN_NEG : WORD_MAX_POS), fl[3:0]});
               end
               OP_CALL_DA, OP_CALL_IRR: begin
                  nv = sp - WORD_TWO;
                  put(nv[7:0], pcn[15:8]);
                  put(nv[7:0] + BYTE_ONE, pcn[7:0]);
                  put(SPH_ADDR, nv[15:8]);
                  put(SPL_ADDR, nv[7:0]);
                  pc_d = (o == OP_CALL_DA) ? {b1, b2} : pv;
               end
               OP_SUB_EXIT: begin
                  pc_d = pair(sp[7:0]);
                  nv = sp + WORD_TWO;
                  put(SPH_ADDR, nv[15:8]);
                  put(SPL_ADDR, nv[7:0]);
               end
               OP_INT_EXIT: begin
                  put(FLAGS_ADDR, rf_q[sp[7:0]]);
                  pc_d = pair(sp[7:0] + BYTE_ONE);
                  nv = sp + WORD_THREE;
                  put(SPH_ADDR, nv[15:8]);
                  put(SPL_ADDR, nv[7:0]);
                  put(IMR_ADDR, interrupt_mask_reg | GIE_MASK);
               end
               OP_PUSH_R, OP_PUSH_IR: begin
                  nv = sp - WORD_ONE;
                  put(nv[7:0], rf_q[oa]);
                  put(SPH_ADDR, nv[15:8]);
                  put(SPL_ADDR, nv[7:0]);
               end
               OP_POP_R, OP_POP_IR: begin
                  nv = sp + WORD_ONE;
                  put(SPH_ADDR, nv[15:8]);
                  put(SPL_ADDR, nv[7:0]);
                  put(oa, rf_q[sp[7:0]]);
               end
               OP_MASK_ALL: put(IMR_ADDR, interrupt_mask_reg & ~GIE_MASK);
               OP_UNMASK_ALL: put(IMR_ADDR, interrupt_mask_reg | GIE_MASK);
               OP_RCF: put(FLAGS_ADDR, {1'b0, fl[6:0]});
               OP_SCF: put(FLAGS_ADDR, {1'b1, fl[6:0]});
               OP_CCF: put(FLAGS_ADDR, {~fl[FC], fl[6:0]});
               OP_GROUP_SEL: put(RP_ADDR, b1);
               OP_JP_IRR: pc_d = pair(radr(rp, b1));
               OP_LD_RX: put(wreg(rp, b1[7:4]), rf_q[b2 + rf_q[wreg(rp, b1[3:0])]]);
               OP_LD_XR: put(b2 + rf_q[wreg(rp, b1[3:0])], rf_q[wreg(rp, b1[7:4])]);
               OP_LD_RIR: put(wreg(rp, b1[7:4]), rf_q[rf_q[wreg(rp, b1[3:0])]]);
               OP_LD_IRR: put(rf_q[wreg(rp, b1[7:4])], rf_q[wreg(rp, b1[3:0])]);
               OP_LD_GG: put(radr(rp, b2), rf_q[radr(rp, b1)]);
               OP_LD_GIG: put(radr(rp, b2), rf_q[rf_q[radr(rp, b1)]]);
               OP_LD_GIM: put(radr(rp, b1), b2);
               OP_LD_IGIM: put(rf_q[radr(rp, b1)], b2);
               OP_LD_IGG: put(rf_q[radr(rp, b2)], rf_q[radr(rp, b1)]);
               default: begin
                  // Compact forms keyed by the low nibble; others act as no-ops.
                  case (lo)
                     LO_JP: begin
                        if (cond(hi, fl)) pc_d = {b1, b2};
                     end
                     LO_JR: begin
                        if (cond(hi, fl)) pc_d = pcn + sext(b1);
                     end
                     LO_COUNT_DOWN_BRANCH: begin
                        put(wreg(rp, hi), rf_q[wreg(rp, hi)] - BYTE_ONE);
                        if (rf_q[wreg(rp, hi)] != BYTE_ONE) pc_d = pcn + sext(b1);
                     end
                     LO_LDIM: put(wreg(rp, hi), b1);
                     LO_LDRG: put(wreg(rp, hi), rf_q[radr(rp, b1)]);
                     LO_LDGR: put(radr(rp, b1), rf_q[wreg(rp, hi)]);
                     default: ;
                  endcase
               end
            endcase
         end
      end
   end

   // Register file; software writes come last and win a clash.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < RF_DEPTH; i++) begin
            rf_q[i] <= BYTE_ZERO;
         end
      end else begin
         for (int p = 0; p < NWP; p++) begin
            if (we[p]) begin
               rf_q[wa[p]] <= wd[p];
            end
         end
         if (REG_WR) begin
            rf_q[REG_ADDR] <= REG_WDATA;
         end
      end
   end

   // Sequencer and ready; ready drops for the whole memory wait.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ready_q <= (state_d == ST_IDLE);
      end
   end

   // Program counter.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         pc_q <= PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   // Memory request; held from the start until the acknowledge.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mem_req_q <= 1'b0;
         mem_ext_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_auto_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         mem_wdata_q <= BYTE_ZERO;
         mem_tgt_q <= BYTE_ZERO;
         mem_r_q <= BYTE_ZERO;
         mem_pair_q <= BYTE_ZERO;
      end else if (mem_go) begin
         mem_req_q <= 1'b1;
         mem_ext_q <= !o[6];
         mem_we_q <= o[4];
         mem_auto_q <= o[0];
         mem_addr_q <= m_addr;
         mem_wdata_q <= m_wdata;
         mem_tgt_q <= m_tgt;
         mem_r_q <= wreg(rp, b1[7:4]);
         mem_pair_q <= wreg(rp, b1[3:0]);
      end else if (MEM_ACK) begin
         mem_req_q <= 1'b0;
      end
   end

   // Software read port; data stand in the cycle after the strobe.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q <= BYTE_ZERO;
      end else if (REG_RD) begin
         rdata_q <= rf_q[REG_ADDR];
      end
   end

   assign INSTR_READY = ready_q;
   assign MEM_REQ = mem_req_q;
   assign MEM_EXT = mem_ext_q;
   assign MEM_WE = mem_we_q;
   assign MEM_ADDR = mem_addr_q;
   assign MEM_WDATA = mem_wdata_q;
   assign REG_RDATA = rdata_q;
   assign PC_VALUE = pc_q;
endmodule // mcu_instruction_execution

//--- tb/exec_chk.sv
// Port checks for the execution core.
module exec_chk (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic INSTR_VALID,
   input wire logic [7:0] INSTR_OPC,
   input wire logic [7:0] INSTR_B1,
   input wire logic [7:0] INSTR_B2,
   input wire logic [1:0] INSTR_LEN,
   input wire logic INSTR_READY,
   input wire logic MEM_REQ,
   input wire logic MEM_EXT,
   input wire logic MEM_WE,
   input wire logic [15:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic [15:0] PC_VALUE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // Next counter, relative and absolute targets, for comparison one cycle on.
   logic [15:0] nxt, rel, abs_t;
   assign nxt = PC_VALUE + 16'(INSTR_LEN);
   assign rel = nxt + {{8{INSTR_B1[7]}}, INSTR_B1};
   assign abs_t = {INSTR_B1, INSTR_B2};
   // An instruction with a given opcode is accepted.
   sequence take(logic [7:0] op);
      INSTR_VALID && INSTR_READY && INSTR_OPC == op;
   endsequence
   chk_req_blocks: assert property (MEM_REQ |-> !INSTR_READY)
      else $error("ready high during transfer");
   chk_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
      else $error("request moved before ack");
   chk_ack_ends: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ && INSTR_READY)
      else $error("transfer not closed after ack");
   chk_prog_read: assert property (take(8'hC2) |=> MEM_REQ && !MEM_EXT && !MEM_WE)
      else $error("bad program read request");
   chk_ext_write: assert property (take(8'h92) |=> MEM_REQ && MEM_EXT && MEM_WE)
      else $error("bad external write request");
   chk_never_jump: assert property (take(8'h0D) |=> PC_VALUE == $past(nxt))
      else $error("never-true jump taken");
   chk_always_jump: assert property (take(8'h8D) |=> PC_VALUE == $past(abs_t))
      else $error("always-true jump missed");
   chk_rel_jump: assert property (take(8'h8B) |=> PC_VALUE == $past(rel))
      else $error("relative target wrong");
   chk_call_jump: assert property (take(8'hD6) |=> PC_VALUE == $past(abs_t) ##0 INSTR_READY)
      else $error("call target wrong");
endmodule // exec_chk
bind mcu_instruction_execution exec_chk chk_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
   .INSTR_OPC(INSTR_OPC), .INSTR_B1(INSTR_B1), .INSTR_B2(INSTR_B2), .INSTR_LEN(INSTR_LEN),
   .INSTR_READY(INSTR_READY), .MEM_REQ(MEM_REQ), .MEM_EXT(MEM_EXT), .MEM_WE(MEM_WE),
   .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .PC_VALUE(PC_VALUE));

//--- tb/mem_model.sv
// Behavioural program and external memory behind the core.
module mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic ext,
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   output logic ack,
   output logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [1:0] wait_q;
   logic slow_q;
   logic [7:0] idx;
   // The two spaces are kept apart by the top index bit.
   assign idx = {ext, addr[6:0]};
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
   // Answers alternate prompt and slow; idle data shows the inverse so stale reads fail.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         wait_q <= 2'h0;
         slow_q <= 1'b0;
         rdata <= 8'h00;
      end else if (req && !ack && wait_q == (slow_q ? 2'h3 : 2'h0)) begin
         ack <= 1'b1;
         wait_q <= 2'h0;
         slow_q <= !slow_q;
         rdata <= mem[idx];
         if (we) mem[idx] <= wdata;
      end else begin
         ack <= 1'b0;
         rdata <= ~rdata;
         if (req && !ack) wait_q <= wait_q + 2'h1;
      end
   end
endmodule // mem_model

//--- tb/mcu_instruction_execution_tb.sv
// Self-checking bench for the execution core.
module mcu_instruction_execution_tb;
   import exec_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_SYS = 1'b0, RST_N = 1'b0, INSTR_VALID = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
   logic [7:0] INSTR_OPC = 8'h00, INSTR_B1 = 8'h00, INSTR_B2 = 8'h00, REG_ADDR = 8'h00, REG_WDATA = 8'h00;
   logic [1:0] INSTR_LEN = 2'h1;
   logic INSTR_READY, MEM_REQ, MEM_EXT, MEM_WE, MEM_ACK;
   logic [15:0] MEM_ADDR, PC_VALUE, pc, ret;
   logic [7:0] MEM_WDATA, MEM_RDATA, REG_RDATA;
   logic [7:0] cops [4] = '{8'hDF, 8'hEF, 8'hEF, 8'hCF};
   logic [7:0] cflg [4] = '{8'h88, 8'h08, 8'h88, 8'h08};
   int n_fail = 0, compares = 0;
   mcu_instruction_execution DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
      .INSTR_OPC(INSTR_OPC), .INSTR_B1(INSTR_B1), .INSTR_B2(INSTR_B2), .INSTR_LEN(INSTR_LEN),
      .INSTR_READY(INSTR_READY), .MEM_REQ(MEM_REQ), .MEM_EXT(MEM_EXT), .MEM_WE(MEM_WE),
      .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .PC_VALUE(PC_VALUE));
   mem_model mem_i (.clk(CLK_SYS), .rst_n(RST_N), .req(MEM_REQ), .ext(MEM_EXT), .we(MEM_WE),
      .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
   initial forever #25 CLK_SYS = ~CLK_SYS;
   // Prints the verdict and ends the run.
   task automatic final_report();
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits, bounded, until the core is free; the first step avoids racing the edge.
   task automatic idle();
      int n;
      #1;
      for (n = 0; n < 40 && INSTR_READY !== 1'b1; n++) @(posedge CLK_SYS) #1;
      if (n == 40) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      idle();
      @(posedge CLK_SYS);
      REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      idle();
      @(posedge CLK_SYS);
      REG_ADDR <= a; REG_RD <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      #1 cmp($sformatf("reg %h", a), {8'h00, exp}, {8'h00, REG_RDATA});
   endtask
   // Offers one instruction after checking the counter that previous steps predict.
   task automatic exe(logic [7:0] op, logic [7:0] b1, logic [7:0] b2, logic [1:0] len);
      idle();
      cmp("pc", pc, PC_VALUE);
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b1; INSTR_OPC <= op; INSTR_B1 <= b1; INSTR_B2 <= b2; INSTR_LEN <= len;
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b0;
      pc = pc + 16'(len);
   endtask
   initial begin
      #2000000 n_fail++;
      final_report();
   end
   initial begin
      pc = 16'h0000;
      repeat (4) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      rd(FLAGS_ADDR, 8'h00);
      rd(IMR_ADDR, 8'h00);
      wr(8'h01, 8'h7F);
      wr(8'h02, 8'h01);
      exe(8'h02, 8'h12, 8'h00, 2'h2);
      rd(8'h01, 8'h80);
      rd(FLAGS_ADDR, 8'h34);
      wr(8'h02, 8'h10);
      exe(8'h22, 8'h12, 8'h00, 2'h2);
      rd(8'h01, 8'h70);
      rd(FLAGS_ADDR, 8'h18);
      exe(8'h52, 8'h12, 8'h00, 2'h2);
      rd(8'h01, 8'h10);
      rd(FLAGS_ADDR, 8'h08);
      foreach (cops[i]) begin
         exe(cops[i], 8'h00, 8'h00, 2'h1);
         rd(FLAGS_ADDR, cflg[i]);
      end
      exe(8'hB0, 8'h01, 8'h00, 2'h2);
      rd(8'h01, 8'h00);
      rd(FLAGS_ADDR, 8'h08);
      exe(8'h9F, 8'h00, 8'h00, 2'h1);
      rd(IMR_ADDR, 8'h80);
      exe(8'h8F, 8'h00, 8'h00, 2'h1);
      rd(IMR_ADDR, 8'h00);
      wr(SPL_ADDR, 8'h80);
      wr(8'h01, 8'hC3);
      exe(8'h70, 8'h01, 8'h00, 2'h2);
      rd(SPL_ADDR, 8'h7F);
      rd(8'h7F, 8'hC3);
      exe(8'h50, 8'h03, 8'h00, 2'h2);
      rd(8'h03, 8'hC3);
      rd(SPL_ADDR, 8'h80);
      exe(8'hD6, 8'h12, 8'h34, 2'h3);
      ret = pc;
      pc = 16'h1234;
      rd(SPL_ADDR, 8'h7E);
      rd(8'h7E, ret[15:8]);
      rd(8'h7F, ret[7:0]);
      exe(8'hAF, 8'h00, 8'h00, 2'h1);
      pc = ret;
      rd(SPL_ADDR, 8'h80);
      exe(8'h8D, 8'h02, 8'h00, 2'h3);
      pc = 16'h0200;
      exe(8'h0D, 8'h40, 8'h00, 2'h3);
      exe(8'h8B, 8'hFC, 8'h00, 2'h2);
      pc = pc - 16'h0004;
      wr(8'h02, 8'h02);
      exe(8'h2A, 8'h06, 8'h00, 2'h2);
      pc = pc + 16'h0006;
      rd(8'h02, 8'h01);
      exe(8'h2A, 8'h06, 8'h00, 2'h2);
      rd(8'h02, 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h05, 8'h10);
      exe(8'hC2, 8'h34, 8'h00, 2'h2);
      rd(8'h03, 8'h4A);
      exe(8'h92, 8'h34, 8'h00, 2'h2);
      wr(8'h03, 8'h40);
      exe(8'h83, 8'h34, 8'h00, 2'h2);
      rd(8'h40, 8'h4A);
      rd(8'h03, 8'h41);
      rd(8'h05, 8'h11);
      exe(8'h62, 8'h12, 8'h00, 2'h2);
      rd(8'h01, 8'hC3);
      rd(FLAGS_ADDR, 8'h48);
      exe(8'hA2, 8'h13, 8'h00, 2'h2);
      rd(8'h01, 8'hC3);
      rd(FLAGS_ADDR, 8'h28);
      exe(8'h60, 8'h01, 8'h00, 2'h2);
      rd(8'h01, 8'h3C);
      rd(FLAGS_ADDR, 8'h08);
      exe(8'h20, 8'h01, 8'h00, 2'h2);
      rd(8'h01, 8'h3D);
      exe(8'hA0, 8'h04, 8'h00, 2'h2);
      rd(8'h05, 8'h12);
      exe(8'hE6, 8'h06, 8'h5A, 2'h3);
      rd(8'h06, 8'h5A);
      wr(8'h80, 8'hC4);
      wr(8'h81, 8'h12);
      wr(8'h82, 8'h00);
      exe(8'hBF, 8'h00, 8'h00, 2'h1);
      pc = 16'h1200;
      rd(SPL_ADDR, 8'h83);
      rd(IMR_ADDR, 8'h80);
      rd(FLAGS_ADDR, 8'hC4);
      exe(8'h31, 8'h20, 8'h00, 2'h2);
      rd(RP_ADDR, 8'h20);
      exe(8'hFF, 8'h00, 8'h00, 2'h1);
      final_report();
   end
endmodule // mcu_instruction_execution_tb
